// ===== logic/gbh_pkg.sv
// Package: bus line encodings, timing figures and controller states for the bus controller
package gbh_pkg;
   localparam int CLK_MHZ = 50;
   localparam int T1_NS = 2000;
   localparam int T1_CYCLES = (T1_NS * CLK_MHZ + 999) / 1000;
   localparam int IFC_US = 100;
   localparam int IFC_CYCLES = IFC_US * CLK_MHZ;
   localparam int CMD_BITS = 7;
   localparam int DATA_BITS = 8;
   localparam int PARITY_BIT = 7;
   localparam logic [7:0] DEFAULT_FREQ_MHZ = 8'h08;
   localparam int SYNC_STAGES = 2;
   localparam int BUF_DEPTH = 2;
   typedef enum logic [2:0] {
      GBH_IDLE,
      GBH_IFC,
      GBH_SETTLE,
      GBH_WAIT_RFD,
      GBH_WAIT_DAC,
      GBH_WAIT_NDAC,
      GBH_RX_READY,
      GBH_RX_ACCEPT
   } gbh_state_t;
endpackage

// ===== logic/gbh_controller.sv
// Bus controller: system controller, talker and listener end of the byte handshake
`timescale 1ns/1ps
module gbh_controller
   import gbh_pkg::*;
#(
   parameter int IFC_LEN = IFC_CYCLES,
   parameter bit PARITY_EN = 1'b0
) (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   // User side: transmit stream
   input wire logic [7:0] TX_DATA_I,
   input wire logic TX_CMD_I,
   input wire logic TX_LAST_I,
   input wire logic TX_VALID_I,
   output logic TX_READY_O,
   // User side: receive stream
   output logic [7:0] RX_DATA_O,
   output logic RX_END_O,
   output logic RX_VALID_O,
   input wire logic RX_READY_I,
   // User side: control and status
   input wire logic SYS_CTRL_I,
   input wire logic TAKE_CTRL_I,
   input wire logic LISTEN_I,
   input wire logic REMOTE_I,
   input wire logic [7:0] FREQ_MHZ_I,
   input wire logic FREQ_SET_I,
   output logic CIC_O,
   output logic SRQ_SEEN_O,
   output logic BUSY_O,
   // Bus pins, active low; *_OE_N_O low means the pin is pulled low, except on DIO where each DIO_N_O bit sets the level
   input wire logic [7:0] DIO_N_I,
   output logic [7:0] DIO_N_O,
   output logic [7:0] DIO_OE_N_O,
   input wire logic DAV_N_I,
   output logic DAV_N_O,
   output logic DAV_OE_N_O,
   input wire logic NRFD_N_I,
   output logic NRFD_N_O,
   output logic NRFD_OE_N_O,
   input wire logic NDAC_N_I,
   output logic NDAC_N_O,
   output logic NDAC_OE_N_O,
   input wire logic EOI_N_I,
   output logic EOI_N_O,
   output logic EOI_OE_N_O,
   input wire logic SRQ_N_I,
   input wire logic IFC_N_I,
   output logic IFC_N_O,
   output logic IFC_OE_N_O,
   output logic ATN_N_O,
   output logic ATN_OE_N_O,
   output logic REN_N_O,
   output logic REN_OE_N_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [7:0] tx_byte(input logic [7:0] b, input logic cmd);
      // Command bytes are seven bits; the top line is forced to parity or zero
      logic [7:0] r;
      r = b;
      if (cmd || PARITY_EN) begin
         r[PARITY_BIT] = PARITY_EN ? ^b[CMD_BITS-1:0] : 1'b0;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [SYNC_STAGES-1:0] s_dav, s_nrfd, s_ndac, s_eoi, s_srq, s_ifc;
   logic [7:0] dio_s1, dio_s2;

   always_ff @(posedge REF_CLK_I) begin
      s_dav <= {s_dav[0], ~DAV_N_I};
      s_nrfd <= {s_nrfd[0], ~NRFD_N_I};
      s_ndac <= {s_ndac[0], ~NDAC_N_I};
      s_eoi <= {s_eoi[0], ~EOI_N_I};
      // Only far-side devices raise SRQ; this end watches it and never pulls it
      s_srq <= {s_srq[0], ~SRQ_N_I};
      s_ifc <= {s_ifc[0], ~IFC_N_I};
      dio_s1 <= ~DIO_N_I;
      dio_s2 <= dio_s1;
   end

   // Wired-low lines: asserted if any party pulls them
   wire dav_a = s_dav[SYNC_STAGES-1];
   wire nrfd_a = s_nrfd[SYNC_STAGES-1];
   wire ndac_a = s_ndac[SYNC_STAGES-1];
   wire eoi_a = s_eoi[SYNC_STAGES-1];
   wire srq_a = s_srq[SYNC_STAGES-1];
   wire ifc_a = s_ifc[SYNC_STAGES-1];

   ////////////////////////////////////////////////////////////////////////////////
   // Two-entry transmit buffer

   logic [9:0] tb_mem [BUF_DEPTH];
   logic tb_wp, tb_rp;
   logic [1:0] tb_cnt;
   wire tb_full = (tb_cnt == 2'(BUF_DEPTH));
   wire tb_empty = (tb_cnt == 2'h0);
   wire tb_push = TX_VALID_I && !tb_full;
   logic tb_pop;
   wire [9:0] tb_head = tb_mem[tb_rp];
   wire [1:0] next_tb_cnt = tb_cnt + 2'(tb_push) - 2'(tb_pop);

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         tb_wp <= 1'b0;
         tb_rp <= 1'b0;
         tb_cnt <= 2'h0;
         TX_READY_O <= 1'b0;
      end else begin
         if (tb_push) begin
            tb_mem[tb_wp] <= {TX_CMD_I, TX_LAST_I, TX_DATA_I};
            tb_wp <= ~tb_wp;
         end
         if (tb_pop) begin
            tb_rp <= ~tb_rp;
         end
         tb_cnt <= next_tb_cnt;
         TX_READY_O <= next_tb_cnt < 2'(BUF_DEPTH);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // T1 count from programmed frequency

   logic [7:0] freq_mhz;
   logic [15:0] t1_load;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         freq_mhz <= DEFAULT_FREQ_MHZ;
      end else if (FREQ_SET_I && FREQ_MHZ_I != 8'h00) begin
         freq_mhz <= FREQ_MHZ_I;
      end
      // Rounded up so the delay never falls short of T1
      t1_load <= 16'((32'(T1_NS) * 32'(freq_mhz) + 32'd999) / 32'd1000);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Handshake state machine

   gbh_state_t state, next_state;
   logic [31:0] cnt;
   logic cic, sending_cmd;

   // Our own IFC pulse comes back through the synchronisers a few cycles late;
   // without this mask it would clear the control we have just taken
   logic [SYNC_STAGES:0] own_ifc;
   wire bus_ifc = ifc_a && (state != GBH_IFC) && (own_ifc == '0);

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         own_ifc <= '0;
      end else begin
         own_ifc <= {own_ifc[SYNC_STAGES-1:0], state == GBH_IFC};
      end
   end

   wire rx_slot = !RX_VALID_O || RX_READY_I;
   assign tb_pop = (state == GBH_IDLE) && cic && !tb_empty && !bus_ifc;

   always_comb begin
      next_state = state;
      unique case (state)
         GBH_IDLE: begin
            if (SYS_CTRL_I && TAKE_CTRL_I && !cic) begin
               next_state = GBH_IFC;
            end else if (tb_pop) begin
               next_state = GBH_SETTLE;
            end else if (LISTEN_I && !tb_empty == 1'b0) begin
               next_state = GBH_RX_READY;
            end
         end
         GBH_IFC: if (cnt == 32'h0) next_state = GBH_IDLE;
         GBH_SETTLE: if (cnt == 32'h0) next_state = GBH_WAIT_RFD;
         GBH_WAIT_RFD: if (!nrfd_a) next_state = GBH_WAIT_DAC;
         GBH_WAIT_DAC: if (!ndac_a) next_state = GBH_WAIT_NDAC;
         GBH_WAIT_NDAC: if (ndac_a) next_state = GBH_IDLE;
         GBH_RX_READY: begin
            // Only move on once the byte can be kept, or it would be acknowledged and lost
            if (dav_a && rx_slot) next_state = GBH_RX_ACCEPT;
            else if (!LISTEN_I) next_state = GBH_IDLE;
         end
         GBH_RX_ACCEPT: if (!dav_a) next_state = GBH_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         state <= GBH_IDLE;
         cnt <= 32'h0;
         cic <= 1'b0;
         sending_cmd <= 1'b0;
         DIO_N_O <= 8'hFF;
         EOI_N_O <= 1'b1;
      end else if (bus_ifc) begin
         state <= GBH_IDLE;
         cic <= 1'b0;
      end else begin
         state <= next_state;
         if (cnt != 32'h0) cnt <= cnt - 32'h1;
         if (state == GBH_IDLE && next_state == GBH_IFC) begin
            cnt <= 32'(IFC_LEN);
            cic <= 1'b1;
         end
         if (tb_pop) begin
            // Byte goes out before DAV, then T1 runs from here
            DIO_N_O <= ~tx_byte(tb_head[7:0], tb_head[9]);
            EOI_N_O <= ~(tb_head[8] && !tb_head[9]);
            sending_cmd <= tb_head[9];
            cnt <= 32'(t1_load > 16'h0 ? t1_load : 16'h1);
         end
      end
   end

   // Receive side: take the byte on the same edge that releases NDAC
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         RX_VALID_O <= 1'b0;
         RX_DATA_O <= 8'h00;
         RX_END_O <= 1'b0;
      end else begin
         if (RX_READY_I) RX_VALID_O <= 1'b0;
         if (state == GBH_RX_READY && dav_a && rx_slot) begin
            RX_DATA_O <= dio_s2;
            RX_END_O <= eoi_a;
            RX_VALID_O <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers, all registered

   wire talking = (state == GBH_SETTLE) || (state == GBH_WAIT_RFD) ||
                  (state == GBH_WAIT_DAC) || (state == GBH_WAIT_NDAC);
   wire dav_on = (state == GBH_WAIT_RFD && !nrfd_a) || (state == GBH_WAIT_DAC);
   // Stall before accepting if the user has not drained the last byte
   wire hold_nrfd = !(state == GBH_RX_READY && !dav_a && rx_slot);
   wire hold_ndac = !(state == GBH_RX_ACCEPT || (state == GBH_RX_READY && dav_a && rx_slot));
   wire listen_drive = LISTEN_I && !talking;
   wire cmd_out = talking && sending_cmd;
   wire eoi_out = talking && !EOI_N_O;
   wire ifc_out = (state == GBH_IFC);
   // REN follows the request directly; a non-system end never touches it
   wire ren_out = SYS_CTRL_I && REMOTE_I;

   ////////////////////////////////////////////////////////////////////////////////
   // Talker lines

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         DIO_OE_N_O <= 8'hFF;
         DAV_N_O <= 1'b1;
         DAV_OE_N_O <= 1'b1;
         EOI_OE_N_O <= 1'b1;
         ATN_N_O <= 1'b1;
         ATN_OE_N_O <= 1'b1;
      end else begin
         DIO_OE_N_O <= {8{!talking}};
         DAV_N_O <= !dav_on;
         DAV_OE_N_O <= !dav_on;
         EOI_OE_N_O <= !eoi_out;
         ATN_N_O <= !cmd_out;
         ATN_OE_N_O <= !cmd_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Listener lines

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         NRFD_N_O <= 1'b0;
         NRFD_OE_N_O <= 1'b1;
         NDAC_N_O <= 1'b0;
         NDAC_OE_N_O <= 1'b1;
      end else begin
         // Open collector: only ever pull low, never drive high
         NRFD_N_O <= 1'b0;
         NRFD_OE_N_O <= !(listen_drive && hold_nrfd);
         NDAC_N_O <= 1'b0;
         NDAC_OE_N_O <= !(listen_drive && hold_ndac);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Management lines and status

   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         IFC_N_O <= 1'b1;
         IFC_OE_N_O <= 1'b1;
         REN_N_O <= 1'b1;
         REN_OE_N_O <= 1'b1;
         CIC_O <= 1'b0;
         SRQ_SEEN_O <= 1'b0;
         BUSY_O <= 1'b0;
      end else begin
         IFC_N_O <= !ifc_out;
         IFC_OE_N_O <= !(ifc_out && SYS_CTRL_I);
         REN_N_O <= !ren_out;
         REN_OE_N_O <= !ren_out;
         CIC_O <= cic;
         SRQ_SEEN_O <= srq_a && cic;
         BUSY_O <= (next_state != GBH_IDLE);
      end
   end

endmodule

// ===== verif/gbh_controller_sva.sv
// Checker: handshake timing and line ownership at the controller pins
`timescale 1ns/1ps
module gbh_controller_sva
   import gbh_pkg::*;
(
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic [7:0] FREQ_MHZ_I,
   input wire logic FREQ_SET_I,
   input wire logic SYS_CTRL_I,
   input wire logic REMOTE_I,
   input wire logic CIC_O,
   input wire logic [7:0] DIO_N_O,
   input wire logic [7:0] DIO_OE_N_O,
   input wire logic DAV_N_O,
   input wire logic DAV_OE_N_O,
   input wire logic NRFD_N_I,
   input wire logic NDAC_N_I,
   input wire logic IFC_N_I,
   input wire logic IFC_OE_N_O,
   input wire logic ATN_N_O,
   input wire logic ATN_OE_N_O,
   input wire logic REN_OE_N_O
);
   wire dav_on = !DAV_OE_N_O && !DAV_N_O;
   logic [7:0] freq;
   int cnt;
   int t1;
   assign t1 = (T1_NS * int'(freq) + 999) / 1000;
   // Restart at each DAV so back-to-back bytes never get early credit
   always_ff @(posedge REF_CLK_I) begin
      freq <= SRST_I ? DEFAULT_FREQ_MHZ : (FREQ_SET_I && FREQ_MHZ_I != 8'h00) ? FREQ_MHZ_I : freq;
      cnt <= (SRST_I || &DIO_OE_N_O || dav_on) ? 0 : cnt + 1;
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);
   ////////////////////////////////
   property p_dav_rfd; $rose(dav_on) |-> $past(NRFD_N_I, 2); endproperty
   a_dav_rfd: assert property (p_dav_rfd) else $error("DAV before ready");
   property p_dav_dac; $fell(dav_on) && IFC_N_I |-> $past(NDAC_N_I, 2); endproperty
   a_dav_dac: assert property (p_dav_dac) else $error("DAV dropped early");
   property p_t1; $rose(dav_on) |-> cnt >= t1; endproperty
   a_t1: assert property (p_t1) else $error("settling too short");
   property p_hold; dav_on && $past(dav_on) |-> $stable(DIO_N_O) && $stable(ATN_N_O); endproperty
   a_hold: assert property (p_hold) else $error("byte moved under DAV");
   property p_cmd7; dav_on && !ATN_OE_N_O && !ATN_N_O |-> DIO_N_O[7] || DIO_OE_N_O[7]; endproperty
   a_cmd7: assert property (p_cmd7) else $error("command top bit set");
   property p_ifc_sys; $fell(IFC_OE_N_O) |-> $past(SYS_CTRL_I); endproperty
   a_ifc_sys: assert property (p_ifc_sys) else $error("IFC not system");
   property p_bus_ifc; (!IFC_N_I && IFC_OE_N_O) [*5] |-> !CIC_O && DAV_OE_N_O; endproperty
   a_bus_ifc: assert property (p_bus_ifc) else $error("IFC not obeyed");
   property p_ren; !REN_OE_N_O |-> $past(SYS_CTRL_I) && $past(REMOTE_I); endproperty
   a_ren: assert property (p_ren) else $error("REN unasked");
endmodule
////////////////////////////////
bind gbh_controller gbh_controller_sva gbh_controller_sva_i (.*);

// ===== verif/gbh_peer.sv
// Far-side bus device: listens to the controller, talks on request
`timescale 1ns/1ps
module gbh_peer
   import gbh_pkg::*;
(
   input wire logic clk,
   input wire logic lis,
   input wire logic [7:0] dio_n,
   input wire logic atn_n,
   input wire logic eoi_n,
   input wire logic dav_n,
   input wire logic nrfd_n,
   input wire logic ndac_n,
   output logic [7:0] p_dio,
   output logic p_eoi,
   output logic p_dav,
   output logic p_nrfd,
   output logic p_ndac
);
   // Outputs only pull low; a released line floats to its pull-up
   logic [9:0] got_q[$];
   ////////////////////////////////
   initial begin
      {p_dio, p_eoi, p_dav, p_nrfd, p_ndac} = '0;
      forever begin
         @(posedge clk);
         if (!lis) begin
            {p_nrfd, p_ndac} <= 2'b00;
         end else begin
            {p_nrfd, p_ndac} <= 2'b11;
            repeat ($urandom_range(6, 1)) @(posedge clk);
            p_nrfd <= 1'b0;
            while (dav_n !== 1'b0) @(posedge clk);
            p_nrfd <= 1'b1;
            got_q.push_back({~atn_n, ~eoi_n, ~dio_n});
            repeat ($urandom_range(9, 1)) @(posedge clk);
            p_ndac <= 1'b0;
            while (dav_n !== 1'b1) @(posedge clk);
            p_ndac <= 1'b1;
         end
      end
   end
   task automatic talk(input logic [7:0] b, input logic last);
      p_dio <= b;
      p_eoi <= last;
      repeat (T1_CYCLES) @(posedge clk);
      while (nrfd_n !== 1'b1) @(posedge clk);
      p_dav <= 1'b1;
      while (ndac_n !== 1'b1) @(posedge clk);
      {p_dav, p_eoi, p_dio} <= '0;
      while (ndac_n !== 1'b0) @(posedge clk);
   endtask
endmodule

// ===== verif/tb.sv
// Testbench: controller against one far-side bus device
`timescale 1ns/1ps
module tb;
   logic REF_CLK_I = 1'b0, SRST_I = 1'b1, TX_CMD_I = 1'b0, TX_LAST_I = 1'b0, TX_VALID_I = 1'b0;
   logic RX_READY_I = 1'b0, SYS_CTRL_I = 1'b0, TAKE_CTRL_I = 1'b0, LISTEN_I = 1'b0;
   logic REMOTE_I = 1'b0, FREQ_SET_I = 1'b0, b_ifc = 1'b0, b_srq = 1'b0, lis = 1'b0, hold = 1'b1;
   logic [7:0] TX_DATA_I = 8'h00, FREQ_MHZ_I = 8'h00, RX_DATA_O, DIO_N_I, DIO_N_O, DIO_OE_N_O, p_dio;
   logic TX_READY_O, RX_END_O, RX_VALID_O, CIC_O, SRQ_SEEN_O, BUSY_O, DAV_N_I, DAV_N_O;
   logic DAV_OE_N_O, NRFD_N_I, NRFD_N_O, NRFD_OE_N_O, NDAC_N_I, NDAC_N_O, NDAC_OE_N_O, EOI_N_I;
   logic EOI_N_O, EOI_OE_N_O, SRQ_N_I, IFC_N_I, IFC_N_O, IFC_OE_N_O, ATN_N_O, ATN_OE_N_O;
   logic REN_N_O, REN_OE_N_O, p_eoi, p_dav, p_nrfd, p_ndac;
   int bad_count = 0, check_count = 0, cyc = 0;
   logic [9:0] exp_q[$], rexp_q[$], rx_q[$];
   // Pull-ups everywhere: a line is low only while some party pulls it
   assign DIO_N_I = ~(~DIO_OE_N_O & ~DIO_N_O | p_dio);
   assign DAV_N_I = ~(~DAV_OE_N_O & ~DAV_N_O | p_dav);
   assign NRFD_N_I = ~(~NRFD_OE_N_O & ~NRFD_N_O | p_nrfd);
   assign NDAC_N_I = ~(~NDAC_OE_N_O & ~NDAC_N_O | p_ndac);
   assign EOI_N_I = ~(~EOI_OE_N_O & ~EOI_N_O | p_eoi);
   assign IFC_N_I = ~(~IFC_OE_N_O & ~IFC_N_O | b_ifc);
   assign SRQ_N_I = ~b_srq;
   gbh_controller #(.IFC_LEN(20)) gbh_controller_i (.*);
   gbh_peer gbh_peer_i (.clk(REF_CLK_I), .lis(lis), .dio_n(DIO_N_I), .atn_n(ATN_N_O | ATN_OE_N_O),
      .eoi_n(EOI_N_I), .dav_n(DAV_N_I), .nrfd_n(NRFD_N_I), .ndac_n(NDAC_N_I), .p_dio(p_dio),
      .p_eoi(p_eoi), .p_dav(p_dav), .p_nrfd(p_nrfd), .p_ndac(p_ndac));
   ////////////////////////////////
   initial forever #10 REF_CLK_I = ~REF_CLK_I;
   always @(posedge REF_CLK_I) begin
      RX_READY_I <= !hold && $urandom_range(1, 0) == 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   // Ready is stable between edges, so the handoff is judged at the falling edge
   always @(negedge REF_CLK_I)
      if (RX_VALID_O === 1'b1 && RX_READY_I) rx_q.push_back({1'b0, RX_END_O, RX_DATA_O});
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({9'h000, got}, {9'h000, exp});
   endtask
   task automatic chk_q(ref logic [9:0] got[$], ref logic [9:0] exp[$]);
      chk(10'(got.size()), 10'(exp.size()));
      while (got.size() > 0 && exp.size() > 0) chk(got.pop_front(), exp.pop_front());
   endtask
   task automatic push(input logic [7:0] d, input logic c, input logic l);
      logic r;
      TX_DATA_I <= d;
      TX_CMD_I <= c;
      TX_LAST_I <= l;
      TX_VALID_I <= 1'b1;
      do begin
         @(negedge REF_CLK_I);
         r = TX_READY_O;
         @(posedge REF_CLK_I);
      end while (r !== 1'b1);
      exp_q.push_back({c, l, c ? {1'b0, d[6:0]} : d});
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      int n;
      logic c;
      logic [7:0] d;
      logic [7:0] fr[2];
      fr = '{8'h00, 8'h32};
      void'($urandom(86));
      repeat (20) @(posedge REF_CLK_I);
      SRST_I <= 1'b0;
      TAKE_CTRL_I <= 1'b1;
      repeat (40) @(posedge REF_CLK_I);
      chk_bit(CIC_O, 1'b0);
      SYS_CTRL_I <= 1'b1;
      for (n = 0; n < 200 && CIC_O !== 1'b1; n++) @(posedge REF_CLK_I);
      TAKE_CTRL_I <= 1'b0;
      chk_bit(CIC_O, 1'b1);
      REMOTE_I <= 1'b1;
      repeat (3) @(posedge REF_CLK_I);
      chk_bit(REN_N_O | REN_OE_N_O, 1'b0);
      REMOTE_I <= 1'b0;
      lis <= 1'b1;
      foreach (fr[k]) begin
         FREQ_MHZ_I <= fr[k];
         FREQ_SET_I <= 1'b1;
         @(posedge REF_CLK_I);
         FREQ_SET_I <= 1'b0;
         for (n = 0; n < 8; n++) begin
            c = 1'($urandom_range(1, 0));
            push(8'($urandom), c, ~c & 1'($urandom_range(1, 0)));
         end
         TX_VALID_I <= 1'b0;
         for (n = 0; n < 4000 && gbh_peer_i.got_q.size() < exp_q.size(); n++) @(posedge REF_CLK_I);
         chk_q(gbh_peer_i.got_q, exp_q);
      end
      b_srq <= 1'b1;
      repeat (5) @(posedge REF_CLK_I);
      chk_bit(SRQ_SEEN_O, 1'b1);
      b_srq <= 1'b0;
      lis <= 1'b0;
      LISTEN_I <= 1'b1;
      fork
         for (int k = 0; k < 5; k++) begin
            d = 8'($urandom);
            rexp_q.push_back({1'b0, 1'(k == 4), d});
            gbh_peer_i.talk(d, k == 4);
         end
         begin
            repeat (600) @(posedge REF_CLK_I);
            chk_bit(NDAC_N_I, 1'b0);
            hold <= 1'b0;
         end
      join
      for (n = 0; n < 400 && rx_q.size() < 5; n++) @(posedge REF_CLK_I);
      chk_q(rx_q, rexp_q);
      b_ifc <= 1'b1;
      repeat (8) @(posedge REF_CLK_I);
      b_ifc <= 1'b0;
      chk_bit(CIC_O, 1'b0);
      report_and_stop();
   end
endmodule
